//--- src/led_port_pkg.sv
`default_nettype none
package led_port_pkg;
   // register location and width
   localparam logic [7:0] REG_ADDR = 8'h05;
   localparam int REG_W = 8;
   // field positions
   localparam int BIT_CAL = 7;
   localparam int BIT_PSM = 6;
   localparam int BIT_DIR = 5;
   localparam int BIT_VAL = 4;
   localparam int BIT_TYPE = 3;
   localparam int BIT_SINK3 = 2;
   localparam int BIT_SINK2 = 1;
   localparam int BIT_SINK1 = 0;
   // value after reset: 0 1 1 0 1 0 1 0
   localparam logic [7:0] REG_RESET = 8'h6a;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic i;
      logic o;
      logic oe;
   } pin_t;
endpackage
`default_nettype wire

//--- src/sync2.sv
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   // first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- src/led_channel_port_control_reg.sv
`default_nettype none
// How it works
// - write bit 7 high starts calibration
// - read bit 7: done flag
// - done clears only on calibration start
// - bit 6 enables power save mode
// - read bit 5 returns dc light pin
// - write bit 5 sets port direction
// - bit 4 holds port value
// - bit 3 selects open drain drive
// - bit 2 enables sink three
// - bit 1 enables sink two
// - bit 0 enables sink one
// - reset value 0110_1010
// - port carries power good unless routed
module led_channel_port_control_reg
   import led_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   input wire logic calibration_done_i,
   input wire logic dc_light_select_input_i,
   input wire logic power_good_routing_i,
   input wire logic power_good_i,
   input wire logic port_pin_i,
   output logic port_pin_o,
   output logic port_pin_oe_o,
   output logic calibration_start_done_o,
   output logic calibration_start_o,
   output logic power_save_enable_o,
   output logic sink1_enable_o,
   output logic sink2_enable_o,
   output logic sink3_enable_o
);
   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [2:0] sync_q;
   logic dcl_s, port_s, done_s;

   sync2 #(.W(3)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({dc_light_select_input_i, port_pin_i, calibration_done_i}),
      .q_o(sync_q)
   );
   assign dcl_s = sync_q[2];
   assign port_s = sync_q[1];
   assign done_s = sync_q[0];

   // ==========================================================
   // control register
   // ==========================================================
   logic [7:0] ctrl_r;
   logic hit_wr, hit_rd, cal_start;
   logic done_r, done_q_r, done_rise;

   // one address decode shared by the write and the read strobe
   function automatic logic addr_hit(input reg_req_t r);
      return r.addr == REG_ADDR;
   endfunction

   assign hit_wr = req_i.wr && addr_hit(req_i);
   assign hit_rd = req_i.rd && addr_hit(req_i);
   // start on each write of a one, so a rewrite restarts the cycle
   assign cal_start = hit_wr && req_i.wdata[BIT_CAL];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= REG_RESET;
      end else if (hit_wr) begin
         ctrl_r <= req_i.wdata;
      end
   end

   // ==========================================================
   // stored fields
   // ==========================================================
   // named views of the stored word
   logic cal_en, psm_en, dir_out, val_bit, open_drain;
   assign cal_en = ctrl_r[BIT_CAL];
   assign psm_en = ctrl_r[BIT_PSM];
   assign dir_out = ctrl_r[BIT_DIR];
   assign val_bit = ctrl_r[BIT_VAL];
   assign open_drain = ctrl_r[BIT_TYPE];

   // ==========================================================
   // calibration done flag
   // ==========================================================
   // resets low, the idle level of the engine's done line
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_q_r <= 1'b0;
      end else begin
         done_q_r <= done_s;
      end
   end

   // an engine finish only counts while calibration is enabled
   assign done_rise = done_s && !done_q_r && cal_en;

   // a finish wins over a start in the same cycle; reads leave the flag
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else if (done_rise) begin
         done_r <= 1'b1;
      end else if (cal_start) begin
         done_r <= 1'b0;
      end
   end

   // ==========================================================
   // read path
   // ==========================================================
   function automatic logic [7:0] read_word(input logic [7:0] c, input logic d,
                                            input logic l, input logic p);
      logic [7:0] w;
      w = c;
      w[BIT_CAL] = d;
      w[BIT_DIR] = l;
      if (!c[BIT_DIR]) begin
         w[BIT_VAL] = p;
      end
      return w;
   endfunction

   logic [7:0] rdata_nxt;
   always_comb begin
      rdata_nxt = read_word(ctrl_r, done_r, dcl_s, port_s);
   end

   // a pulse per accepted read; other addresses get no answer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= hit_rd;
      end
   end

   // holds the last answer until the next read of this register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (hit_rd) begin
         rdata_o <= rdata_nxt;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   logic pin_val, pin_drv;
   always_comb begin
      pin_val = power_good_routing_i ? val_bit : power_good_i;
      // open drain only pulls low
      if (!dir_out) begin
         pin_drv = 1'b0;
      end else if (open_drain) begin
         pin_drv = !pin_val;
      end else begin
         pin_drv = 1'b1;
      end
   end

   // ==========================================================
   // registered outputs: port pin
   // ==========================================================
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_pin_o <= 1'b0;
         port_pin_oe_o <= 1'b0;
      end else begin
         // open drain keeps the data low so a released pin floats high
         port_pin_o <= open_drain ? 1'b0 : pin_val;
         port_pin_oe_o <= pin_drv;
      end
   end

   // ==========================================================
   // registered outputs: calibration
   // ==========================================================
   // the start pulse leads the enable level by one cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         calibration_start_done_o <= REG_RESET[BIT_CAL];
         calibration_start_o <= 1'b0;
      end else begin
         calibration_start_done_o <= cal_en;
         calibration_start_o <= cal_start;
      end
   end

   // ==========================================================
   // registered outputs: converter power save
   // ==========================================================
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         power_save_enable_o <= REG_RESET[BIT_PSM];
      end else begin
         power_save_enable_o <= psm_en;
      end
   end

   // ==========================================================
   // registered outputs: sink enables
   // ==========================================================
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sink1_enable_o <= REG_RESET[BIT_SINK1];
         sink2_enable_o <= REG_RESET[BIT_SINK2];
         sink3_enable_o <= REG_RESET[BIT_SINK3];
      end else begin
         sink1_enable_o <= ctrl_r[BIT_SINK1];
         sink2_enable_o <= ctrl_r[BIT_SINK2];
         sink3_enable_o <= ctrl_r[BIT_SINK3];
      end
   end
endmodule
`default_nettype wire

//--- tb/led_port_props.sv
`default_nettype none
module led_port_props
   import led_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire reg_req_t req_i,
   input wire logic rvalid_o,
   input wire logic port_pin_oe_o,
   input wire logic calibration_start_done_o,
   input wire logic calibration_start_o,
   input wire logic power_save_enable_o,
   input wire logic sink1_enable_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic hit;
   assign hit = req_i.addr == REG_ADDR;
   // ====
   // accesses: outputs settle two edges after a write, the calibration start pulse one edge after
   sequence s_wr; req_i.wr && hit; endsequence
   sequence s_rd; req_i.rd && hit; endsequence
   a_sink1_follow: assert property (s_wr |-> ##2
      sink1_enable_o == $past(req_i.wdata[0], 2)) else $error("bad sink1");
   a_psm_follow: assert property (s_wr |-> ##2
      power_save_enable_o == $past(req_i.wdata[6], 2)) else $error("bad psm");
   a_cal_level: assert property (s_wr |-> ##2
      calibration_start_done_o == $past(req_i.wdata[7], 2)) else $error("bad cal");
   a_cal_pulse: assert property (s_wr ##0 req_i.wdata[7] |-> ##1 calibration_start_o)
      else $error("no start");
   a_pulse_cause: assert property (calibration_start_o |->
      $past(req_i.wr && hit && req_i.wdata[7])) else $error("stray start");
   a_read_valid: assert property (s_rd |=> rvalid_o) else $error("no rvalid");
   a_rvalid_cause: assert property (rvalid_o |-> $past(req_i.rd && hit))
      else $error("stray rvalid");
   a_input_oe: assert property ((s_wr ##0 !req_i.wdata[5]) ##1 !req_i.wr
      |-> ##1 !port_pin_oe_o) else $error("input drives");
endmodule
bind led_channel_port_control_reg led_port_props u_props (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .req_i(req_i),
   .rvalid_o(rvalid_o),
   .port_pin_oe_o(port_pin_oe_o),
   .calibration_start_done_o(calibration_start_done_o),
   .calibration_start_o(calibration_start_o),
   .power_save_enable_o(power_save_enable_o),
   .sink1_enable_o(sink1_enable_o)
);
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_i = 1, calibration_done_i = 0, dc_light_select_input_i = 1;
   logic power_good_routing_i = 1, power_good_i = 0, port_pin_i = 1;
   logic rvalid_o, port_pin_o, port_pin_oe_o, calibration_start_done_o, calibration_start_o;
   logic power_save_enable_o, sink1_enable_o, sink2_enable_o, sink3_enable_o;
   logic [7:0] rdata_o;
   led_port_pkg::reg_req_t req_i = '0;
   int miscompares = 0, tests_run = 0;
   logic start_seen = 1'b0;
   led_channel_port_control_reg dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(req_i),
      .rdata_o(rdata_o),
      .rvalid_o(rvalid_o),
      .calibration_done_i(calibration_done_i),
      .dc_light_select_input_i(dc_light_select_input_i),
      .power_good_routing_i(power_good_routing_i),
      .power_good_i(power_good_i),
      .port_pin_i(port_pin_i),
      .port_pin_o(port_pin_o),
      .port_pin_oe_o(port_pin_oe_o),
      .calibration_start_done_o(calibration_start_done_o),
      .calibration_start_o(calibration_start_o),
      .power_save_enable_o(power_save_enable_o),
      .sink1_enable_o(sink1_enable_o),
      .sink2_enable_o(sink2_enable_o),
      .sink3_enable_o(sink3_enable_o)
   );
   initial forever #25 clk_i = ~clk_i;
   // ====
   // access tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // waits out the two edges before outputs follow
   task automatic wr(input logic [7:0] d);
      @(negedge clk_i) req_i = '{1'b1, 1'b0, 8'h05, d};
      @(negedge clk_i) req_i = '0;
      // the start pulse stands for this one cycle only
      start_seen = calibration_start_o;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_i) req_i = '{1'b0, 1'b1, a, 8'h00};
      // the valid pulse stands for one cycle only, so look right after it
      @(negedge clk_i) req_i = '0;
      chk({7'h00, rvalid_o}, {7'h00, a == 8'h05});
      if (a == 8'h05) chk(rdata_o, e);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ====
   // sequence
   initial begin
      repeat (16) @(negedge clk_i);
      rst_i = 0;
      // let the pin synchronisers fill before the first look
      repeat (2) @(negedge clk_i);
      chk({1'b0, calibration_start_done_o, power_save_enable_o, sink3_enable_o,
         sink2_enable_o, sink1_enable_o, port_pin_o, port_pin_oe_o}, 8'h29);
      rd(8'h05, 8'h6a);
      dc_light_select_input_i = 0;
      wr(8'h07);
      chk({2'h0, start_seen, power_save_enable_o, sink3_enable_o, sink2_enable_o,
         sink1_enable_o, port_pin_oe_o}, 8'h0e);
      rd(8'h05, 8'h17);
      wr(8'h38);
      chk({6'h00, port_pin_o, port_pin_oe_o}, 8'h00);
      wr(8'h28);
      chk({6'h00, port_pin_o, port_pin_oe_o}, 8'h01);
      wr(8'h30);
      chk({6'h00, port_pin_o, port_pin_oe_o}, 8'h03);
      rd(8'h05, 8'h10);
      power_good_routing_i = 0;
      repeat (3) @(negedge clk_i);
      chk({6'h00, port_pin_o, port_pin_oe_o}, 8'h01);
      wr(8'h80);
      chk({6'h00, start_seen, calibration_start_done_o}, 8'h03);
      rd(8'h05, 8'h10);
      calibration_done_i = 1;
      repeat (4) @(negedge clk_i);
      rd(8'h05, 8'h90);
      rd(8'h06, 8'h00);
      rd(8'h05, 8'h90);
      calibration_done_i = 0;
      wr(8'h80);
      rd(8'h05, 8'h10);
      finish_test();
   end
   initial begin
      #20us;
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
